// ==== nvram_sync.sv ====
// Constants package and the two-flop input synchroniser
package nvram_pkg;
  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int          WORD_W      = 16;
  localparam int          ADDR_W      = 4;
  localparam int          WORDS       = 16;
  localparam int          INSTR_W     = 7;
  localparam int          CNT_W       = 5;
  // ----------------------------------------------------------------------
  // Operation codes
  // ----------------------------------------------------------------------
  localparam logic [2:0]  OP_LOCK     = 3'h0;
  localparam logic [2:0]  OP_SAVE     = 3'h1;
  localparam logic [2:0]  OP_WRITE    = 3'h3;
  localparam logic [2:0]  OP_UNLOCK   = 3'h4;
  localparam logic [2:0]  OP_RESTORE  = 3'h5;
  localparam logic [1:0]  OP_READ_HI  = 2'h3;
  // ----------------------------------------------------------------------
  // Link bit positions (count of rising edges seen in the frame)
  // ----------------------------------------------------------------------
  localparam logic [4:0]  CNT_IDLE    = 5'h00;
  localparam logic [4:0]  CNT_START   = 5'h01;
  localparam logic [4:0]  CNT_ADDR    = 5'h04;
  localparam logic [4:0]  CNT_OP      = 5'h07;
  localparam logic [4:0]  CNT_INSTR   = 5'h08;
  localparam logic [4:0]  CNT_DATA    = 5'h17;
  localparam logic [4:0]  CNT_DONE    = 5'h18;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int          CORE_CLK_HZ = 40000000;
  localparam int          SAVE_TIME_MS = 10;
  localparam int          SAVE_CYCLES = SAVE_TIME_MS * (CORE_CLK_HZ / 1000);
  localparam int          SAVE_CNT_W  = 19;
  // ----------------------------------------------------------------------
  // Synchroniser layout and reset values
  // ----------------------------------------------------------------------
  localparam int          SYNC_W      = 4;
  localparam logic [3:0]  SYNC_RST    = 4'hc;
  localparam int          SYNC_SAVE   = 3;
  localparam int          SYNC_RESTORE = 2;
  localparam int          SYNC_ADDR   = 1;
  localparam int          SYNC_CMD    = 0;
endpackage

`timescale 1ns/1ps

module nvram_sync (
  input  wire logic                         i_core_clk,
  input  wire logic                         i_reset,
  input  wire logic [nvram_pkg::SYNC_W-1:0] i_async,
  output logic      [nvram_pkg::SYNC_W-1:0] o_sync
);
  logic [nvram_pkg::SYNC_W-1:0] meta_reg;

  // ----------------------------------------------------------------------
  // Two flops; the first is read by the second only
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      meta_reg <= nvram_pkg::SYNC_RST;
      o_sync   <= nvram_pkg::SYNC_RST;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end
endmodule // nvram_sync

// ==== serial_nvram_command_port.sv ====
// Serial command port of a 16 x 16 RAM shadowed by a nonvolatile array
`timescale 1ns/1ps

// Summary of operation
// - Instruction is eight bits: start one, four address bits, three-bit opcode.
// - Opcode 100 sets the write-enable latch, 000 clears it.
// - Opcode 011 writes the addressed word; opcode 11x reads it.
// - Opcode 001 saves RAM to nonvolatile array; 101 restores it.
// - Bits on serial input are sampled on each shift clock rising edge.
// - Serial output is undriven except while read data shifts out.
// - A write instruction is followed directly by sixteen data bits stored.
// - After a read instruction the output drives sixteen addressed bits.
// - Eighth bit of a read is ignored so input and output share a wire.
// - First read bit from falling edge eight; the rest from rising edges.
// - Chip select falling mid-instruction discards it and clears the shifter.
// - Shift clock may stop anywhere; shifting resumes where it stopped.
// - Write-enable latch is clear after power-up.
// - Writes and saves need a prior unlock after power-up or lock.
// - Latch stays set until reset, lock, or a completed save.
// - Reads work whatever the write-enable latch state.
// - Save and restore pins also start those transfers.
// - A restore sets the restored latch; writes and saves need it.
// - Save pin low saves like the command, under both latches.
// - A save blocks all other functions and clears the latch at the end.
module serial_nvram_command_port #(
  parameter int unsigned P_SAVE_CYCLES = nvram_pkg::SAVE_CYCLES
) (
  input  wire logic i_core_clk,
  input  wire logic i_reset,
  input  wire logic i_shift_clock,
  input  wire logic i_chip_select,
  input  wire logic i_serial_in,
  input  wire logic i_save_pin_n,
  input  wire logic i_restore_pin_n,
  output logic      o_serial_out,
  output logic      o_serial_oe,
  output logic      o_save_busy
);
  typedef enum logic {ST_IDLE, ST_SAVING} core_state_t;

  // Link side
  logic [4:0]                    cnt_reg;
  logic [nvram_pkg::INSTR_W-1:0] instr_reg;
  logic [nvram_pkg::WORD_W-1:0]  data_sh_reg;
  logic [2:0]                    op_next;
  logic                          addr_tgl_reg;
  logic                          cmd_tgl_reg;
  logic [nvram_pkg::ADDR_W-1:0]  rd_addr_hold_reg;
  logic [2:0]                    cmd_op_hold_reg;
  logic [nvram_pkg::ADDR_W-1:0]  cmd_addr_hold_reg;
  logic [nvram_pkg::WORD_W-1:0]  cmd_data_hold_reg;
  logic                          oe_reg;
  logic [nvram_pkg::WORD_W-1:0]  out_word_reg;
  logic [3:0]                    bit_idx;
  // Core side
  logic                          link_clear_reg;
  logic [nvram_pkg::SYNC_W-1:0]  sync_out;
  logic [nvram_pkg::SYNC_W-1:0]  sync_prev_reg;
  core_state_t                   state_reg;
  logic [nvram_pkg::SAVE_CNT_W-1:0] save_cnt_reg;
  logic                          we_latch_reg;
  logic                          restored_reg;
  logic [nvram_pkg::WORD_W-1:0]  rd_word_reg;
  logic [nvram_pkg::WORD_W-1:0]  ram_reg [nvram_pkg::WORDS];
  logic [nvram_pkg::WORD_W-1:0]  nv_reg  [nvram_pkg::WORDS];
  logic                          addr_evt;
  logic                          cmd_evt;
  logic                          save_pin_evt;
  logic                          restore_pin_evt;
  logic                          idle;
  logic                          save_go;
  logic                          save_end;
  logic                          restore_go;
  logic                          write_go;

  assign op_next = {instr_reg[1:0], i_serial_in};

  // ----------------------------------------------------------------------
  // Link: bit counter and shifters (shift clock domain)
  // ----------------------------------------------------------------------
  // Deselect clears frame; static clock
  // Chip select low is the frame's own reset, so a stopped clock cannot
  // leave a stale partial instruction behind.
  always_ff @(posedge i_shift_clock or negedge i_chip_select) begin
    if (!i_chip_select) begin
      cnt_reg     <= nvram_pkg::CNT_IDLE;
      instr_reg   <= '0;
      data_sh_reg <= '0;
    end else if (cnt_reg == nvram_pkg::CNT_IDLE) begin
      if (i_serial_in) begin
        cnt_reg <= nvram_pkg::CNT_START;
      end
    end else if (cnt_reg != nvram_pkg::CNT_DONE) begin
      cnt_reg <= cnt_reg + 5'h01;
      if (cnt_reg < nvram_pkg::CNT_INSTR) begin
        instr_reg <= {instr_reg[5:0], i_serial_in};
      end else begin
        data_sh_reg <= {data_sh_reg[14:0], i_serial_in};
      end
      if (cnt_reg == nvram_pkg::CNT_OP && op_next != nvram_pkg::OP_WRITE &&
          instr_reg[1:0] != nvram_pkg::OP_READ_HI) begin
        cnt_reg <= nvram_pkg::CNT_DONE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Link: handoff words to the core, each announced by a toggle
  // ----------------------------------------------------------------------
  // Held words change only with their toggle, so the core reads them
  // stable once the synchronised toggle edge arrives.
  always_ff @(posedge i_shift_clock or posedge link_clear_reg) begin
    if (link_clear_reg) begin
      addr_tgl_reg      <= 1'b0;
      cmd_tgl_reg       <= 1'b0;
      rd_addr_hold_reg  <= '0;
      cmd_op_hold_reg   <= nvram_pkg::OP_LOCK;
      cmd_addr_hold_reg <= '0;
      cmd_data_hold_reg <= '0;
    end else begin
      // Address known after the fourth address bit; prefetch starts
      if (cnt_reg == nvram_pkg::CNT_ADDR) begin
        rd_addr_hold_reg <= {instr_reg[2:0], i_serial_in};
        addr_tgl_reg     <= ~addr_tgl_reg;
      end
      if (cnt_reg == nvram_pkg::CNT_OP && op_next != nvram_pkg::OP_WRITE &&
          instr_reg[1:0] != nvram_pkg::OP_READ_HI) begin
        cmd_op_hold_reg <= op_next;
        cmd_tgl_reg     <= ~cmd_tgl_reg;
      end
      if (cnt_reg == nvram_pkg::CNT_DATA &&
          instr_reg[2:0] == nvram_pkg::OP_WRITE) begin
        cmd_op_hold_reg   <= nvram_pkg::OP_WRITE;
        cmd_addr_hold_reg <= instr_reg[6:3];
        cmd_data_hold_reg <= {data_sh_reg[14:0], i_serial_in};
        cmd_tgl_reg       <= ~cmd_tgl_reg;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Link: read output
  // ----------------------------------------------------------------------
  // First bit on falling edge
  // The prefetched word has stood for three and a half link periods by now; the
  // core clock must fit its three-cycle sync and fetch inside them.
  always_ff @(negedge i_shift_clock or negedge i_chip_select) begin
    if (!i_chip_select) begin
      oe_reg       <= 1'b0;
      out_word_reg <= '0;
    end else if (cnt_reg == nvram_pkg::CNT_INSTR && !oe_reg &&
                 instr_reg[2:1] == nvram_pkg::OP_READ_HI) begin
      oe_reg       <= 1'b1;
      out_word_reg <= rd_word_reg;
    end
  end

  assign bit_idx      = 4'(nvram_pkg::CNT_DATA - cnt_reg);
  assign o_serial_oe  = oe_reg && (cnt_reg != nvram_pkg::CNT_DONE);
  assign o_serial_out = o_serial_oe && out_word_reg[bit_idx];

  // ----------------------------------------------------------------------
  // Core: crossings and event detection
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    link_clear_reg <= i_reset;
  end

  nvram_sync u_sync (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_async    ({i_save_pin_n, i_restore_pin_n, addr_tgl_reg, cmd_tgl_reg}),
    .o_sync     (sync_out)
  );

  // Previous synced values for edge and toggle detection
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sync_prev_reg <= nvram_pkg::SYNC_RST;
    end else begin
      sync_prev_reg <= sync_out;
    end
  end

  assign addr_evt        = sync_out[nvram_pkg::SYNC_ADDR] ^ sync_prev_reg[nvram_pkg::SYNC_ADDR];
  assign cmd_evt         = sync_out[nvram_pkg::SYNC_CMD] ^ sync_prev_reg[nvram_pkg::SYNC_CMD];
  assign save_pin_evt    = sync_prev_reg[nvram_pkg::SYNC_SAVE] && !sync_out[nvram_pkg::SYNC_SAVE];
  assign restore_pin_evt = sync_prev_reg[nvram_pkg::SYNC_RESTORE] &&
                           !sync_out[nvram_pkg::SYNC_RESTORE];

  // ----------------------------------------------------------------------
  // Core: command decode with save priority
  // ----------------------------------------------------------------------
  // Save blocks everything else
  assign idle       = (state_reg == ST_IDLE);
  assign save_go    = idle && we_latch_reg && restored_reg &&
                      (save_pin_evt || (cmd_evt && cmd_op_hold_reg == nvram_pkg::OP_SAVE));
  assign restore_go = idle && !save_go &&
                      (restore_pin_evt || (cmd_evt && cmd_op_hold_reg == nvram_pkg::OP_RESTORE));
  assign write_go   = idle && !save_go && we_latch_reg && restored_reg &&
                      cmd_evt && cmd_op_hold_reg == nvram_pkg::OP_WRITE;
  assign save_end   = !idle && save_cnt_reg == nvram_pkg::SAVE_CNT_W'(P_SAVE_CYCLES - 1);
  assign o_save_busy = !idle;

  // Save sequencer
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_reg    <= ST_IDLE;
      save_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          save_cnt_reg <= '0;
          if (save_go) begin
            state_reg <= ST_SAVING;
          end
        end
        ST_SAVING: begin
          save_cnt_reg <= save_cnt_reg + 1'b1;
          if (save_end) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      we_latch_reg <= 1'b0;
    end else if (save_end) begin
      we_latch_reg <= 1'b0;
    end else if (idle && cmd_evt && cmd_op_hold_reg == nvram_pkg::OP_LOCK) begin
      we_latch_reg <= 1'b0;
    end else if (idle && cmd_evt && cmd_op_hold_reg == nvram_pkg::OP_UNLOCK) begin
      we_latch_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      restored_reg <= 1'b0;
    end else if (restore_go) begin
      restored_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Core: RAM and nonvolatile array, one entry per generate step
  // ----------------------------------------------------------------------
  // The whole array moves in one cycle; the save time only holds the
  // port busy, as the cells would be during programming.
  for (genvar gi = 0; gi < nvram_pkg::WORDS; gi++) begin : g_word
    always_ff @(posedge i_core_clk) begin
      if (restore_go) begin
        ram_reg[gi] <= nv_reg[gi];
      end else if (write_go && cmd_addr_hold_reg == nvram_pkg::ADDR_W'(gi)) begin
        ram_reg[gi] <= cmd_data_hold_reg;
      end
    end
    // Snapshot taken at the start of a save
    always_ff @(posedge i_core_clk) begin
      if (save_go) begin
        nv_reg[gi] <= ram_reg[gi];
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rd_word_reg <= '0;
    end else if (addr_evt && idle) begin
      rd_word_reg <= ram_reg[rd_addr_hold_reg];
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_reset_locks;
    @(posedge i_core_clk) i_reset |=> !we_latch_reg && idle;
  endproperty
  a_reset_locks: assert property (p_reset_locks) else $error("latch set after reset");

  property p_lock;
    @(posedge i_core_clk) disable iff (i_reset)
      idle && cmd_evt && cmd_op_hold_reg == nvram_pkg::OP_LOCK |=> !we_latch_reg;
  endproperty
  a_lock: assert property (p_lock) else $error("lock command ignored");

  property p_unlock;
    @(posedge i_core_clk) disable iff (i_reset)
      idle && cmd_evt && cmd_op_hold_reg == nvram_pkg::OP_UNLOCK |=> we_latch_reg;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock command ignored");

  property p_locked_write;
    @(posedge i_core_clk) disable iff (i_reset)
      cmd_evt && cmd_op_hold_reg == nvram_pkg::OP_WRITE && !restore_go &&
      !(we_latch_reg && restored_reg) |=>
      ram_reg[cmd_addr_hold_reg] == $past(ram_reg[cmd_addr_hold_reg]);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked write changed RAM");

  property p_write_done;
    @(posedge i_core_clk) disable iff (i_reset)
      write_go |=> ram_reg[cmd_addr_hold_reg] == cmd_data_hold_reg ##1 1'b1;
  endproperty
  a_write_done: assert property (p_write_done) else $error("write not stored");

  property p_save_guard;
    @(posedge i_core_clk) disable iff (i_reset)
      idle && !(we_latch_reg && restored_reg) |=> idle;
  endproperty
  a_save_guard: assert property (p_save_guard) else $error("save started unguarded");

  property p_save_end;
    @(posedge i_core_clk) disable iff (i_reset)
      save_end |=> idle && !we_latch_reg;
  endproperty
  a_save_end: assert property (p_save_end) else $error("save end left latch set");

  property p_save_blocks;
    @(posedge i_core_clk) disable iff (i_reset)
      !idle && !save_end |=> $stable(we_latch_reg) && $stable(restored_reg) &&
                             $stable(rd_word_reg);
  endproperty
  a_save_blocks: assert property (p_save_blocks) else $error("activity during save");

  property p_restore_sets;
    @(posedge i_core_clk) disable iff (i_reset)
      restore_go |=> restored_reg && (!$past(restored_reg) || ram_reg[0] == nv_reg[0]);
  endproperty
  a_restore_sets: assert property (p_restore_sets) else $error("restore incomplete");

  property p_start_bit;
    @(posedge i_shift_clock) disable iff (!i_chip_select)
      cnt_reg == nvram_pkg::CNT_IDLE && !i_serial_in |=> cnt_reg == nvram_pkg::CNT_IDLE;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("frame began on a zero");

  property p_oe_read_only;
    @(posedge i_shift_clock) disable iff (!i_chip_select)
      o_serial_oe |-> instr_reg[2:1] == nvram_pkg::OP_READ_HI && cnt_reg >= nvram_pkg::CNT_INSTR;
  endproperty
  a_oe_read_only: assert property (p_oe_read_only) else $error("output driven outside read");

  cover property (@(posedge i_core_clk) disable iff (i_reset) write_go);
  cover property (@(posedge i_core_clk) disable iff (i_reset) save_end);
  cover property (@(posedge i_core_clk) disable iff (i_reset) restore_go);
  cover property (@(posedge i_shift_clock) disable iff (!i_chip_select)
                  o_serial_oe && cnt_reg == nvram_pkg::CNT_DATA);
endmodule // serial_nvram_command_port

// ==== nvram_host_model.sv ====
// Host model that drives the serial link of the nvram command port
`timescale 1ns/1ps
module nvram_host_model (
  output logic      o_shift_clock,
  output logic      o_chip_select,
  output logic      o_serial_in,
  input  wire logic i_serial_out,
  input  wire logic i_serial_oe
);
  // Link idles with the clock stopped and the device deselected
  initial begin
    o_shift_clock = 1'b0;
    o_chip_select = 1'b0;
    o_serial_in   = 1'b0;
  end

  // One frame, MSB first; a released data line toggles so stale bits never look valid
  // Whole frame shape
  task automatic frame(input logic [25:0] bits, input int n, input int nin, input int stall,
                       output logic [15:0] rd, output int n_oe);
    rd   = 16'h0000;
    n_oe = 0;
    #7;
    o_chip_select = 1'b1;
    for (int i = 0; i < n; i++) begin
      if (i < nin) o_serial_in = bits[25-i];
      else if (i == nin) o_serial_in = ~o_serial_in;
      #62.5;
      n_oe += int'(i_serial_oe === 1'b1);
      rd = {rd[14:0], i_serial_out};
      o_shift_clock = 1'b1;
      #62.5;
      o_shift_clock = 1'b0;
      if (i == stall) #2000;   // Clock stopped mid-frame
    end
    #62.5;
    n_oe += int'(i_serial_oe === 1'b1);
    o_chip_select = 1'b0;
    o_serial_in = ~o_serial_in;
    #250;
  endtask
endmodule // nvram_host_model

// ==== serial_nvram_command_port_bench.sv ====
// Self-checking bench for the serial nvram command port
`timescale 1ns/1ps
module serial_nvram_command_port_bench;
  localparam int unsigned SAVE_N = 200;  // Short save so a whole frame fits inside it
  logic        i_core_clk      = 1'b0;
  logic        i_reset         = 1'b1;
  logic        i_save_pin_n    = 1'b1;
  logic        i_restore_pin_n = 1'b1;
  logic        shift_clock, chip_select, serial_in, serial_out, serial_oe, save_busy;
  logic [15:0] rd;
  int          fail_count = 0;
  int          n_checks   = 0;
  int          cycles     = 0;
  int          busy_len   = 0;
  int          stall      = -1;

  always #12.5 i_core_clk = ~i_core_clk;

  serial_nvram_command_port #(.P_SAVE_CYCLES(SAVE_N)) dut (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_shift_clock(shift_clock),
    .i_chip_select(chip_select), .i_serial_in(serial_in), .i_save_pin_n(i_save_pin_n),
    .i_restore_pin_n(i_restore_pin_n), .o_serial_out(serial_out),
    .o_serial_oe(serial_oe), .o_save_busy(save_busy));

  nvram_host_model host (
    .o_shift_clock(shift_clock), .o_chip_select(chip_select), .o_serial_in(serial_in),
    .i_serial_out(serial_out), .i_serial_oe(serial_oe));

  // Save length meter and hang guard
  always @(posedge i_core_clk) begin
    cycles++;
    if (save_busy === 1'b1) busy_len++;
    if (cycles == 25000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_n(input string what, input int exp, input int got);
    n_checks++;
    if (got != exp) begin
      fail_count++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  function automatic logic [15:0] pat(input logic [3:0] k);
    return {4{k}} ^ 16'h5a3c;
  endfunction

  // ----------------------------------------------------------------------
  // Link and pin helpers
  // ----------------------------------------------------------------------
  task automatic xfer(input logic [3:0] a, input logic [2:0] op, input logic [15:0] d,
                      input logic [15:0] exp);
    int   n_oe;
    logic rdop;
    rdop = (op[2:1] == nvram_pkg::OP_READ_HI);
    host.frame({1'b1, a, op, d, 2'b00}, (rdop || op == nvram_pkg::OP_WRITE) ? 24 : 8,
               rdop ? 8 : 24, stall, rd, n_oe);
    chk_n("drive count", rdop ? 16 : 0, n_oe);
    if (rdop) chk("word", exp, rd);
  endtask

  task automatic rdw(input logic [3:0] a, input logic [15:0] exp);
    xfer(a, 3'h6, 16'h0000, exp);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    xfer(a, nvram_pkg::OP_WRITE, d, 16'h0000);
  endtask

  task automatic md(input logic [2:0] op);
    xfer(4'h0, op, 16'h0000, 16'h0000);
  endtask

  task automatic do_reset();
    @(posedge i_core_clk);
    i_reset <= 1'b1;
    repeat (7) @(posedge i_core_clk);
    i_reset <= 1'b0;
    repeat (4) @(posedge i_core_clk);
  endtask

  // Pins are edge triggered, so one short low pulse gives one action
  task automatic pulse(input logic save);
    @(posedge i_core_clk);
    if (save) i_save_pin_n <= 1'b0;
    else i_restore_pin_n <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    i_save_pin_n    <= 1'b1;
    i_restore_pin_n <= 1'b1;
    repeat (12) @(posedge i_core_clk);
  endtask

  task automatic wait_save(input int exp);
    for (int i = 0; i < 400 && save_busy !== 1'b0; i++) @(posedge i_core_clk);
    chk_n("save time", exp, busy_len);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic s_fill();
    md(nvram_pkg::OP_RESTORE);
    md(nvram_pkg::OP_UNLOCK);
    for (int k = 0; k < nvram_pkg::WORDS; k++) wr(k[3:0], pat(k[3:0]));
    for (int k = 0; k < nvram_pkg::WORDS; k++) rdw(k[3:0], pat(k[3:0]));
  endtask

  task automatic s_lock();
    md(nvram_pkg::OP_LOCK);
    wr(4'h5, 16'h0000);
    rdw(4'h5, pat(4'h5));
    xfer(4'h5, 3'h7, 16'h0000, pat(4'h5));
  endtask

  // Write during a save is dropped; the save also drops the latch
  task automatic s_save_cmd();
    md(nvram_pkg::OP_UNLOCK);
    busy_len = 0;
    md(nvram_pkg::OP_SAVE);
    wr(4'h6, 16'hffff);
    wait_save(SAVE_N);
    wr(4'h7, 16'h1234);
    rdw(4'h6, pat(4'h6));
    rdw(4'h7, pat(4'h7));
    md(nvram_pkg::OP_UNLOCK);
    wr(4'h7, 16'h1234);
    md(nvram_pkg::OP_RESTORE);
    rdw(4'h7, pat(4'h7));
  endtask

  task automatic s_pins();
    md(nvram_pkg::OP_LOCK);
    busy_len = 0;
    pulse(1'b1);
    wait_save(0);
    md(nvram_pkg::OP_UNLOCK);
    wr(4'h3, 16'hbeef);
    busy_len = 0;
    pulse(1'b1);
    wait_save(SAVE_N);
    md(nvram_pkg::OP_UNLOCK);
    wr(4'h3, 16'h0000);
    pulse(1'b0);
    rdw(4'h3, 16'hbeef);
  endtask

  task automatic s_abort_stall();
    int n_oe;
    md(nvram_pkg::OP_LOCK);
    host.frame({1'b1, 4'h0, nvram_pkg::OP_UNLOCK, 18'h00000}, 6, 6, -1, rd, n_oe);
    wr(4'h2, 16'h0f0f);
    rdw(4'h2, pat(4'h2));
    host.frame({2'b00, 1'b1, 4'h4, 3'h6, 16'h0000}, 26, 10, -1, rd, n_oe);
    chk("lead zeros", pat(4'h4), rd);
    stall = 3;
    rdw(4'h9, pat(4'h9));
    stall = -1;
  endtask

  task automatic s_reset_latches();
    do_reset();
    md(nvram_pkg::OP_RESTORE);
    wr(4'h1, 16'h0000);
    rdw(4'h1, pat(4'h1));
    do_reset();
    md(nvram_pkg::OP_UNLOCK);
    wr(4'h1, 16'h0000);
    rdw(4'h1, pat(4'h1));
  endtask

  initial begin
    do_reset();
    s_fill();
    s_lock();
    s_save_cmd();
    s_pins();
    s_abort_stall();
    s_reset_latches();
    stop_test();
  end
endmodule // serial_nvram_command_port_bench
